/* File: rtl/nvmem_consts.svh */
`ifndef NVMEM_CONSTS_SVH
`define NVMEM_CONSTS_SVH

// clock rate of the cpu clock
`define CLK_FREQ_MHZ       40

// data space layout
`define DS_REG_COUNT       16'd32
`define DS_REGIO_END       16'd96
`define DS_END             16'd1120
`define DS_SRAM_BYTES      1024
`define DS_REG_BYTES       32
`define DS_IO_BYTES        64

// pointer register pairs start at working register 26
`define PTR_BASE_IDX       5'd26
`define DISP_MAX           6'd63

// program memory
`define PM_WORDS           8192
`define PM_BOOT_START      13'h1C00

// nonvolatile memory
`define NV_BYTES           512
`define NV_ADDR_W          9
`define NV_TIMER_W         20
`define NV_WRITE_TIME_US   8500
`define NV_READ_HALT       3'd4
`define NV_WRITE_HALT      3'd2
`define NV_MWE_WINDOW      3'd4

// nonvolatile registers, index inside the 64-byte i/o space
`define IO_NV_CTRL         6'h1C
`define IO_NV_DATA         6'h1D
`define IO_NV_ADDR_LO      6'h1E
`define IO_NV_ADDR_HI      6'h1F

// control register bit positions
`define NV_CTRL_READ       0
`define NV_CTRL_STROBE     1
`define NV_CTRL_MWE        2

`endif

/* File: rtl/nvmem_pkg.sv */
package nvmem_pkg;

  typedef enum logic [2:0] {
    MODE_DIRECT,
    MODE_DISP,
    MODE_INDIRECT,
    MODE_PREDEC,
    MODE_POSTINC
  } addr_mode_e;

  typedef enum logic [1:0] {
    PTR_X,
    PTR_Y,
    PTR_Z
  } ptr_sel_e;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_EXEC
  } access_state_e;

endpackage

/* File: rtl/data_space_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nvmem_consts.svh"

module data_space_decoder (
  input  wire logic [15:0] addr,
  output logic             inRegs,
  output logic             inIo,
  output logic             inSram,
  output logic [4:0]       regIdx,
  output logic [5:0]       ioIdx,
  output logic [9:0]       sramIdx
);

  logic [15:0] ioOff;
  logic [15:0] sramOff;

  // region split of the data space
  assign inRegs  = addr < `DS_REG_COUNT;
  assign inIo    = (addr >= `DS_REG_COUNT) && (addr < `DS_REGIO_END);
  assign inSram  = (addr >= `DS_REGIO_END) && (addr < `DS_END);
  assign ioOff   = addr - `DS_REG_COUNT;
  assign sramOff = addr - `DS_REGIO_END;
  assign regIdx  = addr[4:0];
  assign ioIdx   = ioOff[5:0];
  assign sramIdx = sramOff[9:0];

endmodule
`default_nettype wire

/* File: rtl/nv_byte_store.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nvmem_consts.svh"

module nv_byte_store #(
  parameter int WRITE_CYCLES = `NV_WRITE_TIME_US * `CLK_FREQ_MHZ
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic [`NV_ADDR_W-1:0] rdAddr,
  output logic [7:0]                 rdData,
  input  wire logic                  wrStart,
  input  wire logic [`NV_ADDR_W-1:0] wrAddr,
  input  wire logic [7:0]            wrData,
  output logic                       busy
);

  localparam logic [`NV_TIMER_W-1:0] LAST_COUNT = `NV_TIMER_W'(WRITE_CYCLES - 1);

  logic [7:0]                 mem [0:`NV_BYTES-1];
  logic [`NV_TIMER_W-1:0]     timer_q;
  logic [`NV_ADDR_W-1:0]      addr_q;
  logic [7:0]                 data_q;
  logic                       busy_q;
  logic                       finish;

  assign rdData = mem[rdAddr];
  assign busy   = busy_q;
  assign finish = busy_q && (timer_q == '0);

  // self-timed write: the byte lands when the timer runs out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q  <= 1'b0;
      timer_q <= '0;
      addr_q  <= '0;
      data_q  <= 8'h00;
    end else if (ce) begin
      if (wrStart && !busy_q) begin
        busy_q  <= 1'b1;
        timer_q <= LAST_COUNT;
        addr_q  <= wrAddr;
        data_q  <= wrData;
      end else if (finish) begin
        busy_q  <= 1'b0; // R13
      end else if (busy_q) begin
        timer_q <= timer_q - 1'b1;
      end
    end
  end

  // byte array, no reset on purpose
  always_ff @(posedge clk) begin
    if (ce && finish) begin
      mem[addr_q] <= data_q; // R11
    end
  end

endmodule
`default_nettype wire

/* File: rtl/data_memory_and_eeprom_access.sv */
// Functional notes
// [R01] first 96 locations are registers and i/o, next 1024 are sram, 1120 total
// [R02] all registers, i/o registers and sram bytes reachable in every mode
// [R03] five modes: direct, displacement, indirect, pre-decrement, post-increment
// [R04] direct addressing reaches the whole data space
// [R05] displacement adds up to 63 to the second or third pointer pair; the code also applies it to the first pair
// [R06] pre-decrement before the access, post-increment after it
// [R07] working registers 26 to 31 form three 16-bit pointer pairs
// [R08] every sram access takes two cpu clock cycles
// [R09] program memory is 8K 16-bit words with a 13-bit program counter
// [R10] program memory splits into boot and application sections
// [R11] 512 byte nonvolatile store, separate space, single-byte read and write
// [R12] nonvolatile address, data and control registers sit in i/o space
// [R13] nonvolatile write is self-timed and its busy state is visible
// [R14] cpu halted four cycles after a nonvolatile read
// [R15] cpu halted two cycles after a nonvolatile write start
// [R16] software sets master enable then strobe to start a write
// [R17] 9-bit address, upper seven bits read zero, low nine writable
// [R18] strobe starts a write only within four cycles of master enable
// [R19] master enable clears itself four cycles after being set
// [R20] strobe clears when done; busy blocks reads and address changes
// [R21] addresses above the last sram byte are ignored, reads give zero
`timescale 1ns/1ps
`default_nettype none
`include "nvmem_consts.svh"

module data_memory_and_eeprom_access #(
  parameter int WRITE_CYCLES = `NV_WRITE_TIME_US * `CLK_FREQ_MHZ
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  reqValid,
  input  wire logic                  reqWrite,
  input  wire nvmem_pkg::addr_mode_e reqMode,
  input  wire nvmem_pkg::ptr_sel_e   reqPtr,
  input  wire logic [15:0]           reqAddr,
  input  wire logic [5:0]            reqDisp,
  input  wire logic [7:0]            reqWdata,
  output logic [7:0]                 rdata_q,
  output logic                       done_q,
  output logic                       busy_q,
  output logic                       cpuHalt_q,
  output logic                       nvWriteBusy_q,
  input  wire logic [12:0]           programCounter,
  output logic [15:0]                instrWord_q,
  output logic                       inBootSection_q,
  input  wire logic                  progWrite,
  input  wire logic [12:0]           progAddr,
  input  wire logic [15:0]           progData,
  input  wire logic                  bootLock
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0]  regFile [0:`DS_REG_BYTES-1];
  logic [7:0]  ioMem   [0:`DS_IO_BYTES-1];
  logic [7:0]  sram    [0:`DS_SRAM_BYTES-1];
  logic [15:0] progMem [0:`PM_WORDS-1];

  nvmem_pkg::access_state_e state_q;
  logic [15:0] ea_q;
  logic        wr_q;
  logic [7:0]  wdata_q;
  logic        ptrUpd_q;
  logic [4:0]  ptrIdx_q;
  logic [15:0] ptrNew_q;
  logic [2:0]  haltCnt_q;
  logic [2:0]  haltCnt_d;
  logic [2:0]  mweCnt_q;
  logic        nvAddrTop_q;
  logic [7:0]  nvAddrLow_q;
  logic [7:0]  nvData_q;

  ////////////////////////////////////////////////////////////////////////////
  // effective address for the request
  logic        accept;
  logic [4:0]  ptrLoIdx;
  logic [4:0]  ptrHiIdx;
  logic [15:0] ptrVal;
  logic [15:0] ptrDec;
  logic [15:0] ptrInc;
  logic [15:0] dispAddr;
  logic [15:0] eaNext;
  logic        ptrUpdNext;
  logic [15:0] ptrNewNext;

  assign accept     = ce && reqValid && (state_q == nvmem_pkg::ST_IDLE) && (haltCnt_q == 3'd0);
  assign ptrLoIdx   = `PTR_BASE_IDX + {2'b00, reqPtr, 1'b0}; // R07
  assign ptrHiIdx   = ptrLoIdx + 5'd1;
  assign ptrVal     = {regFile[ptrHiIdx], regFile[ptrLoIdx]};
  assign ptrDec     = ptrVal - 16'd1;
  assign ptrInc     = ptrVal + 16'd1;
  // displacement is clipped to its 6-bit field, so never beyond 63
  assign dispAddr   = ptrVal + {10'd0, reqDisp & `DISP_MAX}; // R05
  // mode selection of the effective address
  assign eaNext     = (reqMode == nvmem_pkg::MODE_DIRECT) ? reqAddr :  // R04
                      (reqMode == nvmem_pkg::MODE_DISP)   ? dispAddr :
                      (reqMode == nvmem_pkg::MODE_PREDEC) ? ptrDec :   // R06
                      ptrVal;                                          // R03
  assign ptrUpdNext = (reqMode == nvmem_pkg::MODE_PREDEC) ||
                      (reqMode == nvmem_pkg::MODE_POSTINC);
  assign ptrNewNext = (reqMode == nvmem_pkg::MODE_PREDEC) ? ptrDec : ptrInc; // R06

  ////////////////////////////////////////////////////////////////////////////
  // decode of the latched address
  logic       inRegs;
  logic       inIo;
  logic       inSram;
  logic [4:0] regIdx;
  logic [5:0] ioIdx;
  logic [9:0] sramIdx;

  data_space_decoder u_decoder (
    .addr    (ea_q),
    .inRegs  (inRegs),
    .inIo    (inIo),
    .inSram  (inSram),
    .regIdx  (regIdx),
    .ioIdx   (ioIdx),
    .sramIdx (sramIdx)
  ); // R01

  logic exec;
  logic regWr;
  logic ioWr;
  logic sramWr;
  logic ctrlWr;
  logic nvDataWr;
  logic nvAddrLoWr;
  logic nvAddrHiWr;
  logic nvBusy;
  logic startRead;
  logic startWrite;
  logic mweOn;

  assign exec       = ce && (state_q == nvmem_pkg::ST_EXEC);
  assign regWr      = exec && wr_q && inRegs;  // R02
  assign ioWr       = exec && wr_q && inIo;
  assign sramWr     = exec && wr_q && inSram;  // R21
  assign ctrlWr     = ioWr && (ioIdx == `IO_NV_CTRL); // R12
  assign nvDataWr   = ioWr && (ioIdx == `IO_NV_DATA);
  assign nvAddrLoWr = ioWr && (ioIdx == `IO_NV_ADDR_LO) && !nvBusy; // R20
  assign nvAddrHiWr = ioWr && (ioIdx == `IO_NV_ADDR_HI) && !nvBusy; // R20
  assign mweOn      = mweCnt_q != 3'd0;
  assign startRead  = ctrlWr && wdata_q[`NV_CTRL_READ] && !nvBusy; // R20
  // the enable is sampled before this write, so setting both at once fails
  assign startWrite = ctrlWr && wdata_q[`NV_CTRL_STROBE] && mweOn && !nvBusy; // R18

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile byte store
  logic [8:0] nvAddr;
  logic [7:0] nvRdData;

  assign nvAddr = {nvAddrTop_q, nvAddrLow_q}; // R17

  nv_byte_store #(
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_store (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .rdAddr  (nvAddr),
    .rdData  (nvRdData),
    .wrStart (startWrite),
    .wrAddr  (nvAddr),
    .wrData  (nvData_q),
    .busy    (nvBusy)
  ); // R11

  ////////////////////////////////////////////////////////////////////////////
  // read data selection
  logic [7:0] ctrlRead;
  logic [7:0] ioRead;
  logic [7:0] readByte;

  // strobe reads back as the busy state of the store
  assign ctrlRead = {5'd0, mweOn, nvBusy, 1'b0}; // R13
  assign ioRead   = (ioIdx == `IO_NV_CTRL)    ? ctrlRead :
                    (ioIdx == `IO_NV_DATA)    ? nvData_q :
                    (ioIdx == `IO_NV_ADDR_LO) ? nvAddrLow_q :
                    (ioIdx == `IO_NV_ADDR_HI) ? {7'd0, nvAddrTop_q} : // R17
                    ioMem[ioIdx];
  assign readByte = inRegs ? regFile[regIdx] :
                    inIo   ? ioRead :
                    inSram ? sram[sramIdx] :
                    8'h00; // R21

  ////////////////////////////////////////////////////////////////////////////
  // access sequencer: take, then execute one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q  <= nvmem_pkg::ST_IDLE;
      ea_q     <= 16'h0000;
      wr_q     <= 1'b0;
      wdata_q  <= 8'h00;
      ptrUpd_q <= 1'b0;
      ptrIdx_q <= 5'h00;
      ptrNew_q <= 16'h0000;
    end else if (ce) begin
      case (state_q)
        nvmem_pkg::ST_IDLE: begin
          if (accept) begin
            state_q  <= nvmem_pkg::ST_EXEC;
            ea_q     <= eaNext;
            wr_q     <= reqWrite;
            wdata_q  <= reqWdata;
            ptrUpd_q <= ptrUpdNext;
            ptrIdx_q <= ptrLoIdx;
            ptrNew_q <= ptrNewNext;
          end
        end
        nvmem_pkg::ST_EXEC: begin
          state_q <= nvmem_pkg::ST_IDLE; // R08
        end
        default: begin
          state_q <= nvmem_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // answer to the cpu
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
      done_q  <= 1'b0;
    end else if (ce) begin
      done_q <= exec; // R08
      if (exec && !wr_q) begin
        rdata_q <= readByte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // working registers, pointer write-back on the same edge as the access
  always_ff @(posedge clk) begin
    if (exec && ptrUpd_q) begin
      regFile[ptrIdx_q]        <= ptrNew_q[7:0];  // R06
      regFile[ptrIdx_q + 5'd1] <= ptrNew_q[15:8]; // R07
    end
    if (regWr) begin
      regFile[regIdx] <= wdata_q;
    end
  end

  // plain i/o bytes and sram
  always_ff @(posedge clk) begin
    if (ioWr) begin
      ioMem[ioIdx] <= wdata_q;
    end
    if (sramWr) begin
      sram[sramIdx] <= wdata_q; // R02
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile access registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nvAddrTop_q <= 1'b0;
      nvAddrLow_q <= 8'h00;
      nvData_q    <= 8'h00;
    end else if (ce) begin
      if (nvAddrHiWr) begin
        nvAddrTop_q <= wdata_q[0]; // R17
      end
      if (nvAddrLoWr) begin
        nvAddrLow_q <= wdata_q;
      end
      if (startRead) begin
        nvData_q <= nvRdData; // R11
      end else if (nvDataWr) begin
        nvData_q <= wdata_q;
      end
    end
  end

  // master enable window, reloaded by software, counted down by hardware
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mweCnt_q <= 3'd0;
    end else if (ce) begin
      if (ctrlWr && wdata_q[`NV_CTRL_MWE]) begin
        mweCnt_q <= `NV_MWE_WINDOW; // R16
      end else if (mweOn) begin
        mweCnt_q <= mweCnt_q - 3'd1; // R19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu halt after nonvolatile accesses
  assign haltCnt_d = startRead  ? `NV_READ_HALT :  // R14
                     startWrite ? `NV_WRITE_HALT : // R15
                     (haltCnt_q != 3'd0) ? haltCnt_q - 3'd1 : 3'd0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      haltCnt_q     <= 3'd0;
      cpuHalt_q     <= 1'b0;
      busy_q        <= 1'b0;
      nvWriteBusy_q <= 1'b0;
    end else if (ce) begin
      haltCnt_q     <= haltCnt_d;
      cpuHalt_q     <= haltCnt_d != 3'd0; // R14
      busy_q        <= accept || (haltCnt_d != 3'd0);
      nvWriteBusy_q <= startWrite || nvBusy; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program memory, boot section guarded by the lock input
  logic bootHit;
  logic progWrOk;

  assign bootHit  = progAddr >= `PM_BOOT_START; // R10
  assign progWrOk = ce && progWrite && !(bootHit && bootLock);

  always_ff @(posedge clk) begin
    if (progWrOk) begin
      progMem[progAddr] <= progData; // R09
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instrWord_q     <= 16'h0000;
      inBootSection_q <= 1'b0;
    end else if (ce) begin
      instrWord_q     <= progMem[programCounter]; // R09
      inBootSection_q <= programCounter >= `PM_BOOT_START; // R10
    end
  end

endmodule
`default_nettype wire

/* File: testbench/data_memory_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module data_memory_monitor #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [7:0]  rdata_q,
  input wire logic        done_q,
  input wire logic        busy_q,
  input wire logic        cpuHalt_q,
  input wire logic        nvWriteBusy_q,
  input wire logic [12:0] programCounter,
  input wire logic        inBootSection_q
);
  int wbCnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // length of the current write-busy run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) wbCnt <= 0;
    else if (nvWriteBusy_q) wbCnt <= wbCnt + 1;
    else wbCnt <= 0;
  end

  ////////////////////////////////////////////////////////////////////////
  reset_outputs_a: assert property ($fell(rst) |-> rdata_q == 8'h00 && !done_q && !busy_q
    && !cpuHalt_q && !nvWriteBusy_q) else $error("outputs not clear after reset");
  done_timing_a: assert property ($rose(busy_q) |-> !done_q ##1 done_q)
    else $error("access did not finish in two cycles");
  done_pulse_a: assert property (done_q |=> !done_q) else $error("done longer than one cycle");
  rdata_cause_a: assert property ($changed(rdata_q) |-> done_q)
    else $error("read data changed without completion");
  halt_len_a: assert property ($rose(cpuHalt_q) |-> (cpuHalt_q[*4] ##1 !cpuHalt_q)
    or (cpuHalt_q[*2] ##1 !cpuHalt_q)) else $error("halt length wrong");
  halt_start_a: assert property ($rose(cpuHalt_q) |-> done_q)
    else $error("halt began without an access");
  wbusy_halt_a: assert property ($rose(nvWriteBusy_q) |-> cpuHalt_q)
    else $error("write began without halting the cpu");
  wbusy_time_a: assert property ($fell(nvWriteBusy_q) |-> wbCnt >= WRITE_CYCLES - 1
    && wbCnt <= WRITE_CYCLES + 2) else $error("write time wrong");
  boot_flag_a: assert property (ce |=> inBootSection_q == ($past(programCounter) >= 13'h1C00))
    else $error("boot section flag wrong");
endmodule

`default_nettype wire

/* File: testbench/cpu_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
  input  wire logic             clk,
  input  wire logic             done_q,
  output logic                  reqValid,
  output logic                  reqWrite,
  output nvmem_pkg::addr_mode_e reqMode,
  output nvmem_pkg::ptr_sel_e   reqPtr,
  output logic [15:0]           reqAddr,
  output logic [5:0]            reqDisp,
  output logic [7:0]            reqWdata
);
  bit slow = 1; // random idle gaps between requests
  int lost = 0; // accesses that never saw their completion

  // idle bus at time zero
  initial begin
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqMode = nvmem_pkg::MODE_DIRECT;
    reqPtr = nvmem_pkg::PTR_X;
    reqAddr = 16'h0000;
    reqDisp = 6'h00;
    reqWdata = 8'h00;
  end

  // one access held until its completion pulse is seen
  task automatic access(input logic w, input nvmem_pkg::addr_mode_e m,
                        input nvmem_pkg::ptr_sel_e p, input logic [15:0] a,
                        input logic [5:0] d, input logic [7:0] wd);
    int n;
    if (slow) repeat ($urandom_range(2)) @(posedge clk);
    @(posedge clk);
    #1;
    reqValid = 1'b1;
    reqWrite = w;
    reqMode = m;
    reqPtr = p;
    reqAddr = a;
    reqDisp = d;
    reqWdata = wd;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done_q !== 1'b1 && n < 40);
    if (done_q !== 1'b1) lost++;
    reqValid = 1'b0;
  endtask
endmodule

`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

bind data_memory_and_eeprom_access data_memory_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) mon (
  .clk(clk), .rst(rst), .ce(ce), .rdata_q(rdata_q), .done_q(done_q), .busy_q(busy_q),
  .cpuHalt_q(cpuHalt_q), .nvWriteBusy_q(nvWriteBusy_q), .programCounter(programCounter),
  .inBootSection_q(inBootSection_q));

module tb_top;
  logic clk, rst, ce, reqValid, reqWrite, done_q, busy_q, cpuHalt_q, nvWriteBusy_q;
  logic inBootSection_q, progWrite, bootLock;
  nvmem_pkg::addr_mode_e reqMode;
  nvmem_pkg::ptr_sel_e   reqPtr;
  logic [15:0] reqAddr, instrWord_q, progData;
  logic [12:0] programCounter, progAddr;
  logic [5:0]  reqDisp;
  logic [7:0]  reqWdata, rdata_q, d1, d2;
  logic [7:0]  expQ[$];
  logic [15:0] adr[5] = '{16'h0000, 16'h001F, 16'h0030, 16'h0060, 16'h045F};
  int err_total = 0, checked = 0, cyc = 0, n;

  data_memory_and_eeprom_access #(.WRITE_CYCLES(20)) uut (
    .clk(clk), .rst(rst), .ce(ce), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqMode(reqMode), .reqPtr(reqPtr), .reqAddr(reqAddr), .reqDisp(reqDisp),
    .reqWdata(reqWdata), .rdata_q(rdata_q), .done_q(done_q), .busy_q(busy_q),
    .cpuHalt_q(cpuHalt_q), .nvWriteBusy_q(nvWriteBusy_q), .programCounter(programCounter),
    .instrWord_q(instrWord_q), .inBootSection_q(inBootSection_q), .progWrite(progWrite),
    .progAddr(progAddr), .progData(progData), .bootLock(bootLock));

  cpu_core_model cpu (
    .clk(clk), .done_q(done_q), .reqValid(reqValid), .reqWrite(reqWrite), .reqMode(reqMode),
    .reqPtr(reqPtr), .reqAddr(reqAddr), .reqDisp(reqDisp), .reqWdata(reqWdata));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict;
    chk("lost accesses", 16'(cpu.lost), 16'h0000);
    chk("pending reads", 16'(expQ.size()), 16'h0000);
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cpu.access(1'b1, nvmem_pkg::MODE_DIRECT, nvmem_pkg::PTR_X, a, 6'h00, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    expQ.push_back(e);
    cpu.access(1'b0, nvmem_pkg::MODE_DIRECT, nvmem_pkg::PTR_X, a, 6'h00, 8'h00);
  endtask

  task automatic pw(input logic [12:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    progAddr = a;
    progData = d;
    progWrite = 1'b1;
    @(posedge clk);
    #1;
    progWrite = 1'b0;
  endtask

  task automatic pr(input logic [12:0] a, input logic [15:0] e);
    programCounter = a;
    @(posedge clk);
    #1;
    chk("instrWord_q", instrWord_q, e);
    chk("inBootSection_q", {15'h0000, inBootSection_q}, {15'h0000, a >= 13'h1C00});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // clock and cycle ceiling
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc >= 20000) begin
      err_total++;
      give_verdict();
    end
  end

  // read results against the oldest note
  always @(negedge clk) begin
    if (done_q === 1'b1 && reqWrite === 1'b0 && expQ.size() > 0)
      chk("rdata_q", rdata_q, expQ.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, ce, progWrite, bootLock} = 4'b1100;
    {programCounter, progAddr, progData} = '0;
    void'($urandom(11225));
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    // register and sram edges, one i/o byte and unmapped space
    foreach (adr[i]) begin
      d1 = 8'($urandom);
      wr(adr[i], d1);
      rd(adr[i], d1);
    end
    wr(16'h0460, 8'h5A);
    rd(16'h0460, 8'h00);
    $display("test regions done");
    // pointer modes through X, Y and Z
    {d1, d2} = 16'($urandom);
    wr(16'h001A, 8'h00);
    wr(16'h001B, 8'h01);
    cpu.access(1'b1, nvmem_pkg::MODE_INDIRECT, nvmem_pkg::PTR_X, 16'h0, 6'h00, d1);
    wr(16'h0101, d2);
    expQ.push_back(d1);
    cpu.access(1'b0, nvmem_pkg::MODE_POSTINC, nvmem_pkg::PTR_X, 16'h0, 6'h00, 8'h00);
    rd(16'h001A, 8'h01);
    expQ.push_back(d2);
    cpu.access(1'b0, nvmem_pkg::MODE_INDIRECT, nvmem_pkg::PTR_X, 16'h0, 6'h00, 8'h00);
    expQ.push_back(d1);
    cpu.access(1'b0, nvmem_pkg::MODE_PREDEC, nvmem_pkg::PTR_X, 16'h0, 6'h00, 8'h00);
    rd(16'h001A, 8'h00);
    wr(16'h001E, 8'h00);
    wr(16'h001F, 8'h01);
    cpu.access(1'b1, nvmem_pkg::MODE_DISP, nvmem_pkg::PTR_Z, 16'h0, 6'h3F, d2);
    rd(16'h013F, d2);
    wr(16'h001C, 8'h01);
    wr(16'h001D, 8'h01);
    expQ.push_back(d2);
    cpu.access(1'b0, nvmem_pkg::MODE_DISP, nvmem_pkg::PTR_Y, 16'h0, 6'h3E, 8'h00);
    $display("test pointers done");
    // nonvolatile address, late strobe, timed write, read back
    cpu.slow = 0;
    d1 = 8'($urandom);
    wr(16'h003F, 8'hFF);
    rd(16'h003F, 8'h01);
    wr(16'h003E, 8'hA5);
    wr(16'h003D, d1);
    wr(16'h003C, 8'h04);
    rd(16'h003C, 8'h04);
    rd(16'h003C, 8'h00);
    wr(16'h003C, 8'h02);
    repeat (2) @(posedge clk);
    #1 chk("nvWriteBusy_q", {15'h0000, nvWriteBusy_q}, 16'h0000);
    wr(16'h003C, 8'h04);
    wr(16'h003C, 8'h02);
    rd(16'h003C, 8'h02);
    wr(16'h003E, 8'h11);
    n = 0;
    while (nvWriteBusy_q !== 1'b0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    rd(16'h003C, 8'h00);
    rd(16'h003E, 8'hA5);
    wr(16'h003D, ~d1);
    wr(16'h003C, 8'h01);
    rd(16'h003D, d1);
    $display("test nonvolatile done");
    // program words and boot protection
    progAddr = 13'($urandom_range(13'h1BFF));
    d1 = 8'($urandom);
    pw(progAddr, {d1, ~d1});
    pr(progAddr, {d1, ~d1});
    pw(13'h1C00, 16'hA5A5);
    bootLock = 1'b1;
    pw(13'h1C00, 16'h5A5A);
    pr(13'h1C00, 16'hA5A5);
    // clock enable low freezes the fetch registers
    ce = 1'b0;
    programCounter = 13'h0000;
    repeat (3) @(posedge clk);
    #1 chk("instrWord_q", instrWord_q, 16'hA5A5);
    chk("inBootSection_q", {15'h0000, inBootSection_q}, 16'h0001);
    ce = 1'b1;
    $display("test program done");
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule

`default_nettype wire
